// ### hw/adc_compare_control.sv
// apb-controlled single-step compare control of a software successive-approximation adc
//
// How it works
// - a 4-bit software level code picks one of sixteen reference taps
// - code x selects tap at (x + 0.5)/16 of supply
// - writing one to the start bit starts a compare at once
// - each compare lasts two instruction periods, normal or low speed
// - start bit reads one while busy; writing zero does nothing
// - start bit clears only at compare end, clock halt or ce reset
// - channel and level writes are ignored while a compare runs
// - comparator decision is kept in a readable result bit
// - two channel bits connect at most one analog input pin
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module adc_compare_control
   import adc_compare_pkg::*;
#(
   parameter int NORM_CYCLES = COMPARE_NORM_CYC,
   parameter int SLOW_CYCLES = COMPARE_SLOW_CYC
) (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   // apb slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [31:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic                      pready,
   output logic      [31:0]          prdata,
   output logic                      pslverr,
   // system events
   input  wire logic                 clock_halt,
   input  wire logic                 ce_reset,
   input  wire logic                 low_speed_mode,
   // analog front end
   input  wire logic                 comparator_out,
   output logic      [TAP_COUNT-1:0] tap_select,
   output logic      [CHAN_WIDTH-1:0] pin_connect,
   output logic                      converter_power,
   output logic                      compare_active,
   // interrupt
   output logic                      irq
);

   // ---------------- apb front end ----------------
   logic             pready_q, pready_d;
   logic [31:0]      prdata_q, prdata_d;
   logic             pslverr_q, pslverr_d;
   logic             access_go;
   logic             wr_go;
   logic [7:0]       reg_idx;

   function automatic logic idx_mapped(input logic [7:0] idx);
      case (idx)
         CHANNEL_IDX, REFERENCE_IDX, START_IDX, RESULT_IDX,
         POWER_IDX, IRQ_STATUS_IDX, IRQ_MASK_IDX: idx_mapped = 1'b1;
         default:                                 idx_mapped = 1'b0;
      endcase
   endfunction : idx_mapped

   function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
      hit = (idx == want);
   endfunction : hit

   assign reg_idx   = paddr[9:2];
   // write takes effect on the edge where the master sees pready high
   assign access_go = psel && penable && pready_q;
   assign wr_go     = access_go && pwrite && idx_mapped(reg_idx) && (paddr[1:0] == 2'h0)
                      && (paddr[31:10] == 22'h0);

   // ---------------- register state ----------------
   logic [REF_WIDTH-1:0]  ref_q, ref_d;
   logic [CHAN_WIDTH-1:0] chan_q, chan_d;
   logic                  result_q, result_d;
   logic                  power_q, power_d;
   logic                  status_q, status_d;
   logic                  mask_q, mask_d;
   logic                  irq_q, irq_d;
   logic [CHAN_WIDTH-1:0] pin_q, pin_d;

   // ---------------- compare sequencer ----------------
   cmp_state_t            state_q, state_d;
   logic [CNT_WIDTH-1:0]  cnt_q, cnt_d;
   logic                  start_wr;
   logic                  cmp_done;
   logic                  soft_clear;

   assign soft_clear = clock_halt || ce_reset;
   assign start_wr   = wr_go && hit(reg_idx, START_IDX) && pwdata[START_BIT];
   assign cmp_done   = (state_q == CMP_BUSY) && (cnt_q == CNT_WIDTH'(1));

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         CMP_IDLE: begin
            if (start_wr) begin
               state_d = CMP_BUSY;
            end
         end
         CMP_BUSY: begin
            cnt_d = cnt_q - CNT_WIDTH'(1);
            if (cmp_done) begin
               state_d = CMP_IDLE;
            end
         end
         default: begin
            state_d = CMP_IDLE;
         end
      endcase
      // a new start reloads the full two-period time
      if (start_wr) begin
         state_d = CMP_BUSY;
         cnt_d   = low_speed_mode ? CNT_WIDTH'(SLOW_CYCLES)
                                  : CNT_WIDTH'(NORM_CYCLES);
      end
      if (soft_clear) begin
         state_d = CMP_IDLE;
         cnt_d   = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= CMP_IDLE;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // ---------------- register next values ----------------
   always_comb begin
      ref_d    = ref_q;
      chan_d   = chan_q;
      result_d = result_q;
      power_d  = power_q;
      status_d = status_q;
      mask_d   = mask_q;
      if (wr_go && (state_q != CMP_BUSY)) begin
         if (hit(reg_idx, REFERENCE_IDX)) begin
            ref_d = pwdata[REF_WIDTH-1:0];
         end
         if (hit(reg_idx, CHANNEL_IDX)) begin
            chan_d = pwdata[CHAN_WIDTH-1:0];
         end
      end
      if (wr_go && hit(reg_idx, POWER_IDX)) begin
         power_d = pwdata[POWER_BIT];
      end
      if (wr_go && hit(reg_idx, IRQ_MASK_IDX)) begin
         mask_d = pwdata[DONE_BIT];
      end
      if (wr_go && hit(reg_idx, IRQ_STATUS_IDX) && pwdata[DONE_BIT]) begin
         status_d = 1'b0;
      end
      if (cmp_done && !soft_clear) begin
         result_d = comparator_out;
         status_d = 1'b1;
      end
      if (soft_clear) begin
         ref_d  = REF_RESET;
         chan_d = CHAN_RESET;
      end
      // only one pin may reach the comparator
      case (chan_q)
         CHAN_PIN0: pin_d = 2'h1;
         CHAN_PIN1: pin_d = 2'h2;
         default:   pin_d = 2'h0;
      endcase
      irq_d = status_d && mask_d;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ref_q    <= REF_RESET;
         chan_q   <= CHAN_RESET;
         result_q <= 1'b0;
         power_q  <= 1'b0;
         status_q <= 1'b0;
         mask_q   <= 1'b0;
         irq_q    <= 1'b0;
         pin_q    <= 2'h0;
      end else begin
         ref_q    <= ref_d;
         chan_q   <= chan_d;
         result_q <= result_d;
         power_q  <= power_d;
         status_q <= status_d;
         mask_q   <= mask_d;
         irq_q    <= irq_d;
         pin_q    <= pin_d;
      end
   end

   // ---------------- apb answer ----------------
   always_comb begin
      pready_d  = psel && penable && !pready_q;
      pslverr_d = 1'b0;
      prdata_d  = '0;
      if (psel && penable && !pready_q) begin
         pslverr_d = !idx_mapped(reg_idx) || (paddr[1:0] != 2'h0)
                     || (paddr[31:10] != 22'h0);
         if (!pwrite && !pslverr_d) begin
            case (reg_idx)
               CHANNEL_IDX:    prdata_d[CHAN_WIDTH-1:0] = chan_q;
               REFERENCE_IDX:  prdata_d[REF_WIDTH-1:0]  = ref_q;
               START_IDX:      prdata_d[START_BIT]      = (state_q == CMP_BUSY);
               RESULT_IDX:     prdata_d[RESULT_BIT]     = result_q;
               POWER_IDX:      prdata_d[POWER_BIT]      = power_q;
               IRQ_STATUS_IDX: prdata_d[DONE_BIT]       = status_q;
               IRQ_MASK_IDX:   prdata_d[DONE_BIT]       = mask_q;
               default:        prdata_d                 = '0;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pready_q  <= 1'b0;
         prdata_q  <= '0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= pready_d;
         prdata_q  <= prdata_d;
         pslverr_q <= pslverr_d;
      end
   end

   // ---------------- reference tap select ----------------
   tap_decoder #(
      .CODE_W (REF_WIDTH),
      .TAPS   (TAP_COUNT)
   ) u_taps (
      .clk     (clk),
      .sys_rst (sys_rst),
      .code    (ref_q),
      .tap_q   (tap_select)
   );

   // ---------------- outputs ----------------
   assign pready          = pready_q;
   assign prdata          = prdata_q;
   assign pslverr         = pslverr_q;
   assign pin_connect     = pin_q;
   assign converter_power = power_q;
   assign compare_active  = state_q;
   assign irq             = irq_q;

endmodule : adc_compare_control

// ### hw/adc_compare_pkg.sv
// constants, register map and types for the compare control block
package adc_compare_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0]  CHANNEL_IDX      = 8'h5c;
   localparam logic [7:0]  REFERENCE_IDX    = 8'h5d;
   localparam logic [7:0]  START_IDX        = 8'h5e;
   localparam logic [7:0]  RESULT_IDX       = 8'h5f;
   localparam logic [7:0]  POWER_IDX        = 8'h60;
   localparam logic [7:0]  IRQ_STATUS_IDX   = 8'h61;
   localparam logic [7:0]  IRQ_MASK_IDX     = 8'h62;

   // field layout
   localparam int          REF_WIDTH        = 4;
   localparam int          TAP_COUNT        = 16;
   localparam int          CHAN_WIDTH       = 2;
   localparam int          START_BIT        = 0;
   localparam int          RESULT_BIT       = 0;
   localparam int          POWER_BIT        = 0;
   localparam int          DONE_BIT         = 0;

   // reset values
   localparam logic [3:0]  REF_RESET        = 4'h0;
   localparam logic [1:0]  CHAN_RESET       = 2'h0;

   // channel codes that connect one pin
   localparam logic [1:0]  CHAN_PIN0        = 2'h1;
   localparam logic [1:0]  CHAN_PIN1        = 2'h2;

   // compare time: two instruction periods
   localparam int          CLK_PERIOD_PS    = 25000;
   localparam int          COMPARE_NORM_NS  = 106600;
   localparam int          COMPARE_SLOW_NS  = 213200;
   localparam int          COMPARE_NORM_CYC =
      (COMPARE_NORM_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int          COMPARE_SLOW_CYC =
      (COMPARE_SLOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int          CNT_WIDTH        = 14;

   typedef enum logic [0:0] {
      CMP_IDLE = 1'b0,
      CMP_BUSY = 1'b1
   } cmp_state_t;

endpackage : adc_compare_pkg

// ### hw/tap_decoder.sv
// registered one-hot decoder driving the reference string taps
`timescale 1ns/1ps
module tap_decoder
   import adc_compare_pkg::*;
#(
   parameter int CODE_W = REF_WIDTH,
   parameter int TAPS   = TAP_COUNT
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // level code in, tap select out
   input  wire logic [CODE_W-1:0] code,
   output logic      [TAPS-1:0]   tap_q
);

   logic [TAPS-1:0] tap_d;

   // tap k sits at (k + 0.5)/16 of the supply
   always_comb begin
      tap_d = '0;
      for (int k = 0; k < TAPS; k++) begin
         tap_d[k] = (code == CODE_W'(k));
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tap_q <= {{(TAPS-1){1'b0}}, 1'b1};
      end else begin
         tap_q <= tap_d;
      end
   end

endmodule : tap_decoder

// ### testbench/adc_compare_monitor.sv
// assertion checker for the compare control block
`timescale 1ns/1ps
module adc_compare_monitor
   import adc_compare_pkg::*;
#(
   parameter int NORM_CYCLES = COMPARE_NORM_CYC,
   parameter int SLOW_CYCLES = COMPARE_SLOW_CYC
) (
   input wire logic                  clk, sys_rst, psel, penable, pwrite, pready, pslverr,
   input wire logic                  clock_halt, ce_reset, low_speed_mode, compare_active,
   input wire logic [31:0]           paddr, pwdata,
   input wire logic [TAP_COUNT-1:0]  tap_select,
   input wire logic [CHAN_WIDTH-1:0] pin_connect
);
   logic wr, start_wr, lvl_wr, ev, slow_q;
   int   cnt_q, lim;
   assign wr = psel && penable && pready && pwrite && !pslverr;
   assign start_wr = wr && paddr[9:2] == START_IDX && pwdata[0];
   assign lvl_wr = wr && paddr[9:2] == REFERENCE_IDX;
   assign ev = clock_halt || ce_reset;
   assign lim = slow_q ? SLOW_CYCLES : NORM_CYCLES;
   // busy cycles since the last start, and its speed
   always_ff @(posedge clk) begin
      cnt_q <= (sys_rst || start_wr) ? 0 : cnt_q + int'(compare_active);
      slow_q <= sys_rst ? 1'b0 : start_wr ? low_speed_mode : slow_q;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   start_takes_a: assert property (start_wr && !ev |=> compare_active)
      else $error("compare did not start");
   busy_len_a: assert property ($fell(compare_active) && !$past(ev) && !$past(sys_rst)
      |-> cnt_q == lim) else $error("compare length wrong");
   halt_abort_a: assert property (ev && !start_wr |=> !compare_active)
      else $error("halt did not stop compare");
   no_early_a: assert property (compare_active && !ev && cnt_q + 1 < lim
      |=> compare_active) else $error("compare ended early");
   tap_onehot_a: assert property ($onehot(tap_select))
      else $error("tap select not one-hot");
   tap_follow_a: assert property (lvl_wr && !compare_active && !ev ##1 !ev
      |=> tap_select == (16'h1 << $past(pwdata[3:0], 2))) else $error("tap mismatch");
   level_lock_a: assert property (lvl_wr && compare_active && !ev
      |-> ##2 $stable(tap_select)) else $error("level changed while busy");
   pin_one_a: assert property ($countones(pin_connect) <= 1)
      else $error("two pins connected");
   ready_wait_a: assert property ($rose(penable) && psel |=> pready ##1 !pready)
      else $error("ready timing wrong");
   cover property (start_wr);
   cover property ($fell(compare_active) && slow_q);
   cover property (ev && compare_active);
endmodule : adc_compare_monitor
bind adc_compare_control adc_compare_monitor #(
   .NORM_CYCLES(NORM_CYCLES), .SLOW_CYCLES(SLOW_CYCLES)
) mon (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pready(pready), .pslverr(pslverr), .clock_halt(clock_halt), .ce_reset(ce_reset),
   .low_speed_mode(low_speed_mode), .compare_active(compare_active), .paddr(paddr),
   .pwdata(pwdata), .tap_select(tap_select), .pin_connect(pin_connect));

// ### testbench/tb_top.sv
// self-checking bench for the compare control block
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
   $display("FAIL t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_top
   import adc_compare_pkg::*;
;
   logic        clk = '0, sys_rst = '1, psel = '0, penable = '0, pwrite = '0;
   logic        clock_halt = '0, ce_reset = '0, low_speed_mode = '0, comparator_out = '0;
   logic [31:0] paddr = '0, pwdata = '0, prdata, seed = 32'h15d7c352;
   logic        pready, pslverr, converter_power, compare_active, irq;
   logic [15:0] tap_select;
   logic [1:0]  pin_connect;
   logic [32:0] exp_q[$], ex;
   int          fail_count = 0, samples_checked = 0, c;
   always #12.5 clk = ~clk;
   adc_compare_control #(.NORM_CYCLES(8), .SLOW_CYCLES(16)) DUT (.clk(clk), .sys_rst(sys_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .clock_halt(clock_halt),
      .ce_reset(ce_reset), .low_speed_mode(low_speed_mode), .comparator_out(comparator_out),
      .tap_select(tap_select), .pin_connect(pin_connect), .converter_power(converter_power),
      .compare_active(compare_active), .irq(irq));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : finish_test
   task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d,
                      input logic [32:0] e);
      int n;
      exp_q.push_back(e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {22'h0, i, 2'h0};
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         fail_count++;
         finish_test();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wait_idle(output int k);
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (compare_active === 1'b1 && k < 100);
      if (k >= 100) begin
         fail_count++;
         finish_test();
      end
   endtask : wait_idle
   // pops the oldest note at each completed transfer
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1) begin
         ex = exp_q.pop_front();
         `CHK({pslverr, pwrite ? 32'h0 : prdata}, ex)
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      finish_test();
   end
   initial begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      apb(0, REFERENCE_IDX, 0, 0);
      apb(0, START_IDX, 0, 0);
      apb(0, 8'h70, 0, {1'b1, 32'h0});
      apb(1, 8'h70, 1, {1'b1, 32'h0});
      for (int k = 0; k < 16; k++) begin
         apb(1, REFERENCE_IDX, k, 0);
         repeat (2) @(posedge clk);
         `CHK(tap_select, 16'h1 << k)
      end
      for (int k = 0; k < 4; k++) begin
         apb(1, CHANNEL_IDX, k, 0);
         repeat (2) @(posedge clk);
         `CHK(pin_connect, k == 1 ? 2'h1 : k == 2 ? 2'h2 : 2'h0)
      end
      apb(1, POWER_IDX, 1, 0);
      apb(1, IRQ_MASK_IDX, 1, 0);
      apb(0, POWER_IDX, 0, 1);
      `CHK(converter_power, 1'b1)
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         comparator_out <= seed[0];
         low_speed_mode <= i[0];
         apb(1, START_IDX, 1, 0);
         wait_idle(c);
         `CHK(c, (i[0] ? 16 : 8) + 1)
         comparator_out <= ~seed[0];
         apb(0, RESULT_IDX, 0, {32'h0, seed[0]});
         apb(0, IRQ_STATUS_IDX, 0, 1);
         `CHK(irq, 1'b1)
         apb(1, IRQ_MASK_IDX, 0, 0);
         repeat (2) @(posedge clk);
         `CHK(irq, 1'b0)
         apb(1, IRQ_MASK_IDX, 1, 0);
         repeat (2) @(posedge clk);
         `CHK(irq, 1'b1)
         apb(1, IRQ_STATUS_IDX, 1, 0);
         repeat (2) @(posedge clk);
         `CHK(irq, 1'b0)
      end
      apb(1, START_IDX, 1, 0);
      apb(0, START_IDX, 0, 1);
      apb(1, REFERENCE_IDX, 9, 0);
      apb(1, CHANNEL_IDX, 2, 0);
      wait_idle(c);
      apb(0, REFERENCE_IDX, 0, 15);
      apb(0, CHANNEL_IDX, 0, 3);
      apb(1, IRQ_STATUS_IDX, 1, 0);
      apb(1, START_IDX, 0, 0);
      apb(0, START_IDX, 0, 0);
      for (int h = 0; h < 2; h++) begin
         apb(1, REFERENCE_IDX, 7, 0);
         apb(1, START_IDX, 1, 0);
         clock_halt <= (h == 0);
         ce_reset <= (h == 1);
         @(posedge clk);
         clock_halt <= 1'b0;
         ce_reset <= 1'b0;
         apb(0, START_IDX, 0, 0);
         apb(0, REFERENCE_IDX, 0, 0);
         apb(0, IRQ_STATUS_IDX, 0, 0);
      end
      finish_test();
   end
endmodule : tb_top
